// File: verilog/ieeclo_top.sv
`timescale 1ns/1ps
`default_nettype none
module ieeclo_top
   import ieeclo_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic system_control,
   input wire logic bus_clear_request,
   input wire logic remote_enable_request,
   input wire logic remote_enable_value,
   input wire logic secondary_address_set,
   input wire logic [6:0] secondary_address_value,
   input wire logic time_limit_set,
   input wire logic [4:0] time_limit_value,
   input wire logic device_trigger_request,
   input wire logic lockout_request,
   input wire logic [4:0] target_address,
   input wire logic [6:0] target_secondary,
   input wire logic async_start,
   input wire logic async_complete,
   input wire logic async_abort_request,
   input wire logic nrfd_in,
   input wire logic ndac_in,
   output logic ifc_out,
   output logic ren_out,
   output logic atn_out,
   output logic cic_out,
   output logic [7:0] dio_out,
   output logic dav_out,
   output logic [6:0] secondary_address,
   output logic secondary_enabled,
   output logic [4:0] time_limit_code,
   output logic async_busy,
   output logic timeout_flag,
   output logic error_flag,
   output logic [3:0] error_code_result,
   output logic remote_prev,
   output logic op_done
);
   ieclo_st_e st_r;
   ieclo_st_e st_nxt;
   logic [3:0] tick_cnt_r;
   logic us_tick_r;
   logic [29:0] us_cnt_r;
   logic [6:0] ifc_cnt_r;
   logic hs_start_r;
   logic [7:0] hs_byte;
   logic hs_done;
   logic hs_abort;
   logic [7:0] hs_dio;
   logic hs_dav;
   wire [29:0] limit_w = tmo_us(time_limit_code);
   wire limit_on_w = (limit_w != 30'h0);
   // Expiry waits one tick past the limit, since the first free-running tick after a start may come early.
   wire expired_w = limit_on_w && (us_cnt_r > limit_w);
   wire cmd_phase_w = (st_r != IECLO_IDLE) && (st_r != IECLO_IFC);
   wire async_stop_w = async_busy && (async_abort_request || expired_w);
   wire sad_valid_w = (secondary_address_value >= SAD_LO) && (secondary_address_value <= SAD_HI);
   wire sad_off_w = (secondary_address_value == SAD_OFF_A) || (secondary_address_value == SAD_OFF_B);
   wire [7:0] lad_w = LISTEN_BASE | {3'b000, target_address};
   wire [7:0] sec_w = {1'b0, target_secondary};
   wire idle_w = (st_r == IECLO_IDLE);
   ////////////////////////////////////////////////////////////////////////////
   // Microsecond tick and timeout counter.
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         tick_cnt_r <= 4'h0;
         us_tick_r <= 1'b0;
      end else begin
         us_tick_r <= (tick_cnt_r == 4'(TICK_CYC - 1));
         tick_cnt_r <= (tick_cnt_r == 4'(TICK_CYC - 1)) ? 4'h0 : tick_cnt_r + 4'h1;
      end
   end
   wire op_start_w = (idle_w && (bus_clear_request || device_trigger_request || lockout_request))
      || (async_start && !async_busy);
   always_ff @(posedge clk_sys) begin
      if (!reset_n || op_start_w) us_cnt_r <= 30'h0;
      else if (us_tick_r && !expired_w) us_cnt_r <= us_cnt_r + 30'h1;
   end
   ////////////////////////////////////////////////////////////////////////////
   // Command sequencer.
   always_comb begin
      st_nxt = st_r;
      unique case (st_r)
         IECLO_IDLE: begin
            if (bus_clear_request && system_control) st_nxt = IECLO_IFC;
            else if (device_trigger_request) st_nxt = IECLO_LAD;
            else if (lockout_request) st_nxt = IECLO_LLO;
         end
         IECLO_IFC: if (us_tick_r && ifc_cnt_r == 7'(IFC_TICKS)) st_nxt = IECLO_IDLE;
         IECLO_LAD: if (hs_done) st_nxt = secondary_enabled ? IECLO_SAD : IECLO_GET;
         IECLO_SAD: if (hs_done) st_nxt = IECLO_GET;
         IECLO_GET: if (hs_done) st_nxt = IECLO_UNT;
         IECLO_UNT: if (hs_done) st_nxt = IECLO_UNL;
         IECLO_UNL: if (hs_done) st_nxt = IECLO_IDLE;
         IECLO_LLO: if (hs_done) st_nxt = IECLO_IDLE;
      endcase
      if (cmd_phase_w && expired_w) st_nxt = IECLO_IDLE;
   end
   assign hs_abort = cmd_phase_w && expired_w;
   wire enter_cmd_w = (st_nxt != st_r) && (st_nxt != IECLO_IDLE) && (st_nxt != IECLO_IFC);
   always_comb begin
      hs_byte = CMD_UNL;
      unique case (st_nxt)
         IECLO_LAD: hs_byte = lad_w;
         IECLO_SAD: hs_byte = (secondary_address_value == secondary_address) ? {1'b0, secondary_address} : sec_w;
         IECLO_GET: hs_byte = CMD_GET;
         IECLO_UNT: hs_byte = CMD_UNT;
         IECLO_LLO: hs_byte = CMD_LLO;
         default: hs_byte = CMD_UNL;
      endcase
   end
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         st_r <= IECLO_IDLE;
         ifc_cnt_r <= 7'h0;
         hs_start_r <= 1'b0;
         ifc_out <= 1'b0;
         atn_out <= 1'b0;
         cic_out <= 1'b0;
      end else begin
         st_r <= st_nxt;
         hs_start_r <= enter_cmd_w;
         if (st_r != IECLO_IFC) ifc_cnt_r <= 7'h0;
         else if (us_tick_r) ifc_cnt_r <= ifc_cnt_r + 7'h1;
         ifc_out <= (st_nxt == IECLO_IFC);
         if (st_r == IECLO_IFC && st_nxt == IECLO_IDLE) begin
            cic_out <= 1'b1;
            atn_out <= 1'b1;
         end else if (enter_cmd_w) atn_out <= 1'b1;
      end
   end
   ieeclo_handshake u_hs (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .start(hs_start_r),
      .abort(hs_abort),
      .byte_in(hs_byte),
      .nrfd_in(nrfd_in),
      .ndac_in(ndac_in),
      .dio_out(hs_dio),
      .dav_out(hs_dav),
      .done(hs_done)
   );
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         dio_out <= 8'h00;
         dav_out <= 1'b0;
      end else begin
         dio_out <= hs_dio;
         dav_out <= hs_dav;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Settings, remote enable, async transfer and error reporting.
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         ren_out <= 1'b0;
         remote_prev <= 1'b0;
         secondary_address <= SAD_OFF_A;
         secondary_enabled <= 1'b0;
         time_limit_code <= 5'h0;
         async_busy <= 1'b0;
         timeout_flag <= 1'b0;
         error_flag <= 1'b0;
         error_code_result <= ERR_NONE;
         op_done <= 1'b0;
      end else begin
         op_done <= 1'b0;
         if (remote_enable_request && system_control) begin
            ren_out <= remote_enable_value;
            remote_prev <= ren_out;
            error_flag <= 1'b0;
            error_code_result <= {3'b000, ren_out};
         end
         if ((remote_enable_request || (bus_clear_request && idle_w)) && !system_control) begin
            error_flag <= 1'b1;
            error_code_result <= ERR_NOSAC;
         end
         if (secondary_address_set && sad_off_w) secondary_enabled <= 1'b0;
         else if (secondary_address_set && sad_valid_w) begin
            secondary_address <= secondary_address_value;
            secondary_enabled <= 1'b1;
         end
         if (time_limit_set && time_limit_value <= TMO_MAX_CODE) time_limit_code <= time_limit_value;
         if (op_start_w) timeout_flag <= 1'b0;
         if (async_start && !async_busy) async_busy <= 1'b1;
         else if (async_busy && async_complete && !async_stop_w) begin
            async_busy <= 1'b0;
            op_done <= 1'b1;
         end else if (async_stop_w) begin
            async_busy <= 1'b0;
            error_flag <= 1'b1;
            error_code_result <= async_abort_request ? ERR_ABORT : ERR_TIMEOUT;
            timeout_flag <= !async_abort_request;
            op_done <= 1'b1;
         end
         if (hs_abort) begin
            error_flag <= 1'b1;
            error_code_result <= ERR_BUS;
            timeout_flag <= 1'b1;
         end
         if ((st_r == IECLO_UNL || st_r == IECLO_LLO) && hs_done) op_done <= 1'b1;
      end
   end
   chk_ifc_min_width: assert property (@(posedge clk_sys) disable iff (!reset_n)
      $fell(ifc_out) |-> $past(ifc_cnt_r) == 7'(IFC_TICKS)) else $error("clear pulse short");
   chk_cic_after_ifc: assert property (@(posedge clk_sys) disable iff (!reset_n)
      $fell(ifc_out) |-> cic_out && atn_out) else $error("not in charge after clear");
   chk_no_sac_ren: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (remote_enable_request && !system_control) |=> $stable(ren_out) && error_code_result == ERR_NOSAC)
      else $error("remote enable changed without control");
   chk_ren_follow: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (remote_enable_request && system_control) |=> ren_out == $past(remote_enable_value)
      && error_code_result == {3'b000, $past(ren_out)}) else $error("remote enable wrong");
   chk_sad_disable: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (secondary_address_set && sad_off_w) |=> !secondary_enabled) else $error("secondary not off");
   chk_sad_store: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (secondary_address_set && sad_valid_w) |=> secondary_enabled
      && secondary_address == $past(secondary_address_value)) else $error("secondary not stored");
   chk_abort_err: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (async_busy && async_abort_request) |=> !async_busy && error_code_result == ERR_ABORT)
      else $error("abort not reported");
   chk_ifc_idle_clear: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (!system_control && !ifc_out) |=> !ifc_out) else $error("clear without control");
   chk_trig_order: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (st_r == IECLO_GET && hs_done && !hs_abort) |=> st_r == IECLO_UNT) else $error("trigger order");
   chk_tmo_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !time_limit_set |=> $stable(time_limit_code)) else $error("time limit changed on its own");
endmodule
`default_nettype wire

// File: verilog/ieeclo_pkg.sv
package ieeclo_pkg;
   localparam int CLK_HZ = 10000000;
   localparam int IFC_MIN_US = 100;
   localparam int TICK_CYC = CLK_HZ / 1000000;
   localparam int IFC_TICKS = IFC_MIN_US;
   localparam logic [4:0] TMO_MAX_CODE = 5'h11;
   localparam logic [6:0] SAD_OFF_A = 7'h00;
   localparam logic [6:0] SAD_OFF_B = 7'h7F;
   localparam logic [6:0] SAD_LO = 7'h60;
   localparam logic [6:0] SAD_HI = 7'h7E;
   localparam logic [7:0] CMD_LLO = 8'h11;
   localparam logic [7:0] CMD_GET = 8'h08;
   localparam logic [7:0] CMD_UNT = 8'h5F;
   localparam logic [7:0] CMD_UNL = 8'h3F;
   localparam logic [7:0] LISTEN_BASE = 8'h20;
   localparam logic [3:0] ERR_NONE = 4'h0;
   localparam logic [3:0] ERR_NOSAC = 4'h5;
   localparam logic [3:0] ERR_ABORT = 4'h6;
   localparam logic [3:0] ERR_BUS = 4'hE;
   localparam logic [3:0] ERR_TIMEOUT = 4'hF;
   typedef enum logic [1:0] {IECLO_HS_IDLE, IECLO_HS_NRFD, IECLO_HS_DAV} ieclo_hs_e;
   typedef enum logic [2:0] {IECLO_IDLE, IECLO_IFC, IECLO_LAD, IECLO_SAD, IECLO_GET, IECLO_UNT,
      IECLO_UNL, IECLO_LLO} ieclo_st_e;
   // Minimum time limit in microseconds per code, rounded up, zero for disabled.
   function automatic logic [29:0] tmo_us(input logic [4:0] code);
      logic [29:0] v;
      v = 30'h0;
      unique case (code)
         5'd1: v = 30'd10;
         5'd2: v = 30'd30;
         5'd3: v = 30'd100;
         5'd4: v = 30'd300;
         5'd5: v = 30'd1000;
         5'd6: v = 30'd3000;
         5'd7: v = 30'd10000;
         5'd8: v = 30'd30000;
         5'd9: v = 30'd100000;
         5'd10: v = 30'd300000;
         5'd11: v = 30'd1000000;
         5'd12: v = 30'd3000000;
         5'd13: v = 30'd10000000;
         5'd14: v = 30'd30000000;
         5'd15: v = 30'd100000000;
         5'd16: v = 30'd300000000;
         5'd17: v = 30'd1000000000;
         default: v = 30'h0;
      endcase
      return v;
   endfunction
endpackage

// File: verilog/ieeclo_handshake.sv
`timescale 1ns/1ps
`default_nettype none
module ieeclo_handshake
   import ieeclo_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic start,
   input wire logic abort,
   input wire logic [7:0] byte_in,
   input wire logic nrfd_in,
   input wire logic ndac_in,
   output logic [7:0] dio_out,
   output logic dav_out,
   output logic done
);
   ieclo_hs_e st_r;
   ieclo_hs_e st_nxt;
   wire ready_w = !nrfd_in;
   wire accepted_w = !ndac_in;
   ////////////////////////////////////////////////////////////////////////////
   // Three-wire source handshake: wait ready, raise valid, wait accept.
   always_comb begin
      st_nxt = st_r;
      unique case (st_r)
         IECLO_HS_IDLE: if (start) st_nxt = IECLO_HS_NRFD;
         IECLO_HS_NRFD: if (ready_w) st_nxt = IECLO_HS_DAV;
         IECLO_HS_DAV: if (accepted_w) st_nxt = IECLO_HS_IDLE;
         default: st_nxt = IECLO_HS_IDLE;
      endcase
      if (abort) st_nxt = IECLO_HS_IDLE;
   end
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         st_r <= IECLO_HS_IDLE;
         dio_out <= 8'h00;
         dav_out <= 1'b0;
         done <= 1'b0;
      end else begin
         st_r <= st_nxt;
         if (start) dio_out <= byte_in;
         dav_out <= (st_nxt == IECLO_HS_DAV);
         done <= !abort && (st_r == IECLO_HS_DAV) && accepted_w;
      end
   end
   chk_valid_after_ready: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (st_r == IECLO_HS_NRFD && ready_w && !abort) |=> dav_out) else $error("valid not raised");
endmodule
`default_nettype wire

// File: verification/ieeclo_instr_model.sv
`timescale 1ns/1ps
`default_nettype none
module ieeclo_instr_model (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic atn_out,
   input wire logic dav_out,
   input wire logic ren_out,
   input wire logic ifc_out,
   input wire logic [7:0] dio_out,
   input wire logic [4:0] my_addr,
   input wire logic [3:0] stall,
   input wire logic refuse,
   output logic nrfd_in,
   output logic ndac_in,
   output logic byte_seen,
   output logic [7:0] byte_val,
   output logic remote_mode
);
   logic dav_q;
   logic listening;
   logic [3:0] cnt;
   always @(posedge clk_sys) begin
      byte_seen <= 1'b0;
      dav_q <= dav_out;
      cnt <= (dav_out != dav_q) ? 4'h0 : (cnt == 4'hF) ? cnt : cnt + 4'h1;
      if (!reset_n) begin
         {nrfd_in, ndac_in, remote_mode, listening, cnt} <= {4'hC, 4'h0};
      end else if (!dav_out) begin
         ndac_in <= 1'b1;
         nrfd_in <= (cnt < stall);
      end else begin
         nrfd_in <= 1'b1;
         if (cnt >= stall && ndac_in && !refuse) begin
            ndac_in <= 1'b0;
            byte_seen <= 1'b1;
            byte_val <= dio_out;
            if (atn_out && dio_out == (8'h20 | {3'h0, my_addr})) begin
               listening <= 1'b1;
               remote_mode <= ren_out;
            end
            if (atn_out && dio_out == 8'h3F) begin
               listening <= 1'b0;
            end
         end
      end
      if (reset_n && ifc_out) begin
         listening <= 1'b0;
      end
      if (reset_n && !ren_out) begin
         remote_mode <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// File: verification/tb_ieeclo_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_ieeclo_top;
   import ieeclo_pkg::*;
   logic clk_sys = 1'b0, reset_n = 1'b0, sc = 1'b0, clr = 1'b0, ren_rq = 1'b0, ren_v = 1'b0;
   logic sad_set = 1'b0, tl_set = 1'b0, trg = 1'b0, llo = 1'b0, refuse = 1'b0, r_exp = 1'b0;
   logic a_st = 1'b0, a_cp = 1'b0, a_ab = 1'b0;
   logic [6:0] sad_v = 7'h00;
   logic [4:0] tl_v = 5'h00, tgt = 5'h00;
   logic [3:0] stall = 4'h0;
   logic ifc, ren, atn, cic, dav, sec_en, busy, tmo, err_f, rprev, op_done, nrfd, ndac, seen, remote;
   logic [7:0] dio, bval;
   logic [7:0] q[$];
   logic [7:0] ex[5];
   logic [6:0] sad_q;
   logic [4:0] tl_q;
   logic [3:0] ecode;
   int mismatches = 0, n_compared = 0, seed = 32'hfd67, i, k, n;
   always #50 clk_sys = ~clk_sys;
   always @(posedge clk_sys) if (seen) q.push_back(bval);
   ieeclo_top dut (.clk_sys(clk_sys), .reset_n(reset_n), .system_control(sc), .bus_clear_request(clr),
      .remote_enable_request(ren_rq), .remote_enable_value(ren_v), .secondary_address_set(sad_set),
      .secondary_address_value(sad_v), .time_limit_set(tl_set), .time_limit_value(tl_v),
      .device_trigger_request(trg), .lockout_request(llo), .target_address(tgt), .target_secondary(sad_v),
      .async_start(a_st), .async_complete(a_cp), .async_abort_request(a_ab), .nrfd_in(nrfd), .ndac_in(ndac),
      .ifc_out(ifc), .ren_out(ren), .atn_out(atn), .cic_out(cic), .dio_out(dio), .dav_out(dav),
      .secondary_address(sad_q), .secondary_enabled(sec_en), .time_limit_code(tl_q), .async_busy(busy),
      .timeout_flag(tmo), .error_flag(err_f), .error_code_result(ecode), .remote_prev(rprev),
      .op_done(op_done));
   ieeclo_instr_model instr (.clk_sys(clk_sys), .reset_n(reset_n), .atn_out(atn), .dav_out(dav),
      .ren_out(ren), .ifc_out(ifc), .dio_out(dio), .my_addr(tgt), .stall(stall), .refuse(refuse),
      .nrfd_in(nrfd), .ndac_in(ndac), .byte_seen(seen), .byte_val(bval), .remote_mode(remote));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic exp_en(input logic [6:0] v);
      return v >= SAD_LO && v <= SAD_HI;
   endfunction
   task check(input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e) begin
         mismatches++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task end_sim;
      $display("mismatches=%0d n_compared=%0d", mismatches, n_compared);
      if (mismatches == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task step(input int c);
      repeat (c) @(negedge clk_sys);
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      step(1);
      s = 1'b0;
   endtask
   task give_up(input logic ok);
      if (!ok) begin
         mismatches++;
         end_sim();
      end
   endtask
   task wait_op;
      n = 0;
      while (op_done !== 1'b1 && n < 20000) begin
         step(1);
         n++;
      end
      if (op_done !== 1'b1) begin
         mismatches++;
         end_sim();
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      step(3);
      reset_n = 1'b1;
      check({ifc, ren, atn, cic, err_f, tl_q}, 0);
      pulse(clr);
      step(1);
      check({ifc, err_f, ecode}, {2'b01, ERR_NOSAC});
      ren_v = 1'b1;
      pulse(ren_rq);
      step(1);
      check({ren, ecode}, {1'b0, ERR_NOSAC});
      sc = 1'b1;
      pulse(clr);
      n = 0;
      while (ifc === 1'b1 && n < 3000) begin
         step(1);
         n++;
      end
      give_up(ifc !== 1'b1);
      check(n >= IFC_MIN_US * TICK_CYC, 1);
      step(2);
      check({cic, atn}, 2'b11);
      for (i = 0; i < 5; i++) begin
         ren_v = (i == 4) ? 1'b1 : 1'($random(seed));
         pulse(ren_rq);
         step(1);
         check(ren, ren_v);
         check(ecode, {3'b000, r_exp});
         check(rprev, r_exp);
         r_exp = ren_v;
      end
      for (i = 0; i < 6; i++) begin
         sad_v = (i == 0) ? 7'h00 : (i == 1) ? 7'h7F : (i == 2) ? 7'h60 : (i == 3) ? 7'h7E : 7'h6A;
         if (i == 4) sad_v = 7'h60 + 7'($unsigned($random(seed)) % 31);
         pulse(sad_set);
         step(1);
         check(sec_en, exp_en(sad_v));
         if (exp_en(sad_v)) check(sad_q, sad_v);
      end
      for (i = 0; i <= 18; i++) begin
         tl_v = 5'(i);
         pulse(tl_set);
         step(1);
         check(tl_q, (i > 17) ? 17 : i);
      end
      tl_v = 5'h01;
      pulse(tl_set);
      for (k = 0; k < 2; k++) begin
         tgt = 5'($unsigned($random(seed)) % 31);
         stall = 4'($random(seed) & 3);
         ex = '{8'h20 | {3'h0, tgt}, {1'b0, sad_v}, CMD_GET, CMD_UNT, CMD_UNL};
         if (k == 1) ex = '{ex[0], CMD_GET, CMD_UNT, CMD_UNL, 8'h00};
         q.delete();
         pulse(trg);
         wait_op();
         check(q.size(), 5 - k);
         for (i = 0; i < q.size(); i++) check(q[i], ex[i]);
         check(remote, 1);
         sad_v = 7'h00;
         pulse(sad_set);
      end
      pulse(llo);
      wait_op();
      check({q[q.size() - 1], atn}, {CMD_LLO, 1'b1});
      ren_v = 1'b0;
      pulse(ren_rq);
      step(2);
      check(remote, 0);
      refuse = 1'b1;
      pulse(trg);
      n = 0;
      while (ecode !== ERR_BUS && n < 3000) begin
         step(1);
         n++;
      end
      give_up(ecode === ERR_BUS);
      check({err_f, tmo, ecode}, {2'b11, ERR_BUS});
      check(n >= 10 * TICK_CYC, 1);
      refuse = 1'b0;
      reset_n = 1'b0;
      step(3);
      reset_n = 1'b1;
      check({tl_q, tmo, err_f}, 0);
      pulse(a_st);
      pulse(a_cp);
      pulse(a_ab);
      step(1);
      check({busy, err_f, ecode}, {2'b00, ERR_NONE});
      pulse(a_st);
      step(1);
      check(busy, 1);
      pulse(a_ab);
      step(1);
      check({busy, err_f, ecode}, {2'b01, ERR_ABORT});
      tl_v = 5'h01;
      pulse(tl_set);
      pulse(a_st);
      n = 0;
      while (tmo !== 1'b1 && n < 3000) begin
         step(1);
         n++;
      end
      give_up(tmo === 1'b1);
      check({tmo, busy, ecode, n >= 10 * TICK_CYC}, {2'b10, ERR_TIMEOUT, 1'b1});
      end_sim();
   end
endmodule
`default_nettype wire
